/* File: rtl/afhi_pkg.sv */
package afhi_pkg;
	localparam int ADDR_W = 26;
	localparam int DATA_W = 16;
	localparam int PAGE_W = 4;
	localparam int CLK_PS = 5000;
	// times in ns, counts derived from 5 ns period
	localparam int RP_NS   = 200;
	localparam int RPH_NS  = 50;
	localparam int ACC_NS  = 110;
	localparam int PACC_NS = 25;
	localparam int CE_NS   = 110;
	localparam int OE_NS   = 25;
	localparam int WP_NS   = 50;
	localparam int WH_NS   = 20;
	localparam int AS_NS   = 10;
	localparam int CLK_NS  = 5;
	function automatic int up_cyc(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int RP_CYC   = up_cyc(RP_NS);
	localparam int RPH_CYC  = up_cyc(RPH_NS);
	localparam int ACC_CYC  = up_cyc(ACC_NS > CE_NS ? ACC_NS : CE_NS);
	localparam int PACC_CYC = up_cyc(PACC_NS);
	localparam int OE_CYC   = up_cyc(OE_NS);
	localparam int WP_CYC   = up_cyc(WP_NS);
	localparam int WH_CYC   = up_cyc(WH_NS);
	localparam int AS_CYC   = up_cyc(AS_NS);
	localparam int CNT_W    = 8;

	typedef enum logic [1:0] {
		AFHI_CMD_READ,
		AFHI_CMD_WRITE,
		AFHI_CMD_RESET
	} afhi_cmd_type;

	typedef struct packed {
		afhi_cmd_type       cmd;
		logic [ADDR_W-1:0]  addr;
		logic [DATA_W-1:0]  wdata;
	} afhi_req_type;

	typedef struct packed {
		logic               rst_n;
		logic               ce_n;
		logic               oe_n;
		logic               we_n;
	} afhi_ctl_type;
endpackage

/* File: rtl/afhi_host.sv */
`timescale 1ns/1ps
module afhi_host
	import afhi_pkg::*;
(
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// user request side
	input  wire logic               req_valid_i,
	input  wire afhi_req_type       req_i,
	output logic                    req_ready_o,
	output logic                    rsp_valid_o,
	output logic [DATA_W-1:0]       rsp_data_o,
	// flash pins
	output afhi_ctl_type            ctl_o,
	output logic [ADDR_W-1:0]       address_bus_o,
	output logic [DATA_W-1:0]       data_bus_o,
	output logic                    data_bus_oe_o,
	input  wire logic [DATA_W-1:0]  data_bus_i,
	input  wire logic               ready_busy_i,
	// status
	output logic                    busy_o,
	output logic                    flash_ready_o
);
	typedef enum logic [3:0] {
		S_IDLE, S_RST, S_RSTH, S_RSETUP, S_RWAIT, S_RDONE,
		S_WSETUP, S_WPULSE, S_WHOLD
	} afhi_state_type;

	afhi_state_type         state_r;
	logic [CNT_W-1:0]       cnt_r;
	logic [ADDR_W-1:0]      last_addr_r;
	logic                   sel_r;
	logic [DATA_W-1:0]      din_q1_r;
	logic [DATA_W-1:0]      din_q2_r;
	logic                   rb_q1_r;
	logic                   rb_q2_r;
	logic                   page_hit;
	logic                   cnt_done;
	logic [CNT_W-1:0]       rst_low_r;

	assign cnt_done = (cnt_r == '0);
	// page hit only while still selected after a completed read of any kind
	assign page_hit = sel_r &&
		(req_i.addr[ADDR_W-1:PAGE_W] == last_addr_r[ADDR_W-1:PAGE_W]);

	// pin inputs pass two flops
	always_ff @(posedge clk_i) begin
		din_q1_r <= data_bus_i;
		din_q2_r <= din_q1_r;
		rb_q1_r  <= ready_busy_i;
		rb_q2_r  <= rb_q1_r;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flash_ready_o <= 1'b0;
		end else begin
			flash_ready_o <= rb_q2_r;
		end
	end

	// length of the reset pulse the host is driving, saturating
	always_ff @(posedge clk_i) begin
		if (rst_i || ctl_o.rst_n) begin
			rst_low_r <= '0;
		end else if (rst_low_r != '1) begin
			rst_low_r <= rst_low_r + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r       <= S_RST;
			cnt_r         <= CNT_W'(RP_CYC);
			ctl_o         <= '{rst_n: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
				we_n: 1'b1};
			address_bus_o <= '0;
			data_bus_o    <= '0;
			data_bus_oe_o <= 1'b0;
			req_ready_o   <= 1'b0;
			rsp_valid_o   <= 1'b0;
			rsp_data_o    <= '0;
			busy_o        <= 1'b1;
			last_addr_r   <= '0;
			sel_r         <= 1'b0;
		end else begin
			rsp_valid_o <= 1'b0;
			if (!cnt_done) begin
				cnt_r <= cnt_r - 1'b1;
			end
			unique case (state_r)
			S_IDLE: begin
				if (req_valid_i && req_ready_o) begin
					req_ready_o <= 1'b0;
					busy_o      <= 1'b1;
					unique case (req_i.cmd)
					AFHI_CMD_RESET: begin
						// chip select high through reset
						ctl_o   <= '{rst_n: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
							we_n: 1'b1};
						data_bus_oe_o <= 1'b0;
						sel_r   <= 1'b0;
						cnt_r   <= CNT_W'(RP_CYC);
						state_r <= S_RST;
					end
					AFHI_CMD_WRITE: begin
						// drop output drive first; never both low
						ctl_o.oe_n    <= 1'b1;
						ctl_o.ce_n    <= 1'b0;
						address_bus_o <= req_i.addr;
						data_bus_o    <= req_i.wdata;
						sel_r         <= 1'b0;
						cnt_r         <= CNT_W'(AS_CYC);
						state_r       <= S_WSETUP;
					end
					default: begin
						ctl_o.ce_n    <= 1'b0;
						ctl_o.oe_n    <= 1'b0;
						ctl_o.we_n    <= 1'b1;
						address_bus_o <= req_i.addr;
						last_addr_r   <= req_i.addr;
						// same address under held select starts nothing new
						if (sel_r && req_i.addr == last_addr_r) begin
							cnt_r <= CNT_W'(OE_CYC);
						end else if (page_hit) begin
							cnt_r <= CNT_W'(PACC_CYC);
						end else begin
							cnt_r <= CNT_W'(ACC_CYC);
						end
						state_r <= S_RWAIT;
					end
					endcase
				end
			end
			S_RST: begin
				// release only after minimum pulse width
				if (cnt_done) begin
					ctl_o.rst_n <= 1'b1;
					cnt_r       <= CNT_W'(RPH_CYC);
					state_r     <= S_RSTH;
				end
			end
			S_RSTH: begin
				// no access until hold passes and the device reports ready;
				// a busy line stuck low stalls the host here
				if (cnt_done && rb_q2_r) begin
					state_r     <= S_IDLE;
					req_ready_o <= 1'b1;
					busy_o      <= 1'b0;
				end
			end
			S_RWAIT: begin
				if (cnt_done) begin
					state_r <= S_RDONE;
				end
			end
			S_RDONE: begin
				rsp_data_o  <= din_q2_r;
				rsp_valid_o <= 1'b1;
				// keep select low so the next read can be a page access
				sel_r       <= 1'b1;
				state_r     <= S_IDLE;
				req_ready_o <= 1'b1;
				busy_o      <= 1'b0;
			end
			S_WSETUP: begin
				if (cnt_done) begin
					ctl_o.we_n    <= 1'b0;
					data_bus_oe_o <= 1'b1;
					cnt_r         <= CNT_W'(WP_CYC);
					state_r       <= S_WPULSE;
				end
			end
			S_WPULSE: begin
				// rising strobe captures data in the device
				if (cnt_done) begin
					ctl_o.we_n <= 1'b1;
					ctl_o.ce_n <= 1'b1;
					cnt_r      <= CNT_W'(WH_CYC);
					state_r    <= S_WHOLD;
				end
			end
			S_WHOLD: begin
				if (cnt_done) begin
					data_bus_oe_o <= 1'b0;
					state_r       <= S_IDLE;
					req_ready_o   <= 1'b1;
					busy_o        <= 1'b0;
				end
			end
			default: state_r <= S_IDLE;
			endcase
		end
	end

	a_no_contend: assert property (@(posedge clk_i) disable iff (rst_i)
		!(!ctl_o.oe_n && !ctl_o.we_n))
		else $error("output drive and write strobe low together");

	a_reset_desel: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctl_o.rst_n |-> ctl_o.ce_n)
		else $error("chip select low during hardware reset");

	sequence s_rst_start;
		$fell(ctl_o.rst_n);
	endsequence
	a_reset_width: assert property (@(posedge clk_i) disable iff (rst_i)
		s_rst_start |-> !ctl_o.rst_n [*8])
		else $error("reset pulse too short");

	a_reset_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctl_o.rst_n |-> !req_ready_o && !data_bus_oe_o)
		else $error("access allowed during reset");

	a_write_drive: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(ctl_o.we_n) |-> !ctl_o.ce_n && ctl_o.oe_n)
		else $error("write strobe without select");

	a_read_wait: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(rsp_valid_o) |-> !$past(ctl_o.oe_n, 2))
		else $error("read data taken before output drive");

	a_reset_long: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(ctl_o.rst_n) |-> rst_low_r >= CNT_W'(RP_CYC))
		else $error("reset released before minimum pulse");
endmodule // afhi_host

/* File: test/afhi_flash_model.sv */
`timescale 1ns/1ps
module afhi_flash_model
	import afhi_pkg::*;
(
	// clock and pins from host
	input  wire logic               clk_i,
	input  wire afhi_ctl_type       ctl_i,
	input  wire logic [ADDR_W-1:0]  address_bus_i,
	input  wire logic [DATA_W-1:0]  data_bus_i,
	// core supply above lockout
	input  wire logic               supply_ok_i,
	// device answers
	output logic [DATA_W-1:0]       data_bus_o,
	output logic                    ready_busy_o
);
	// sleep to standby time is not given; plain default
	parameter int STBY_CYC = 20;
	// count starts one edge after the address moves
	localparam int NAP_CYC = ACC_CYC + 30 / CLK_NS - 1;
	logic [ADDR_W-1:0] a_r  = '0;
	logic [ADDR_W-1:0] wa_r = '1;
	logic [DATA_W-1:0] wd_r = '0;
	logic [DATA_W-1:0] last_r = '0;
	logic [7:0]        cnt_r = '0;
	logic [7:0]        hold_r = '0;
	logic              page_r = 1'b0;
	logic              wr_r = 1'b0;
	logic              sel;
	logic              done;
	logic              drv;
	logic              nap;
	logic              deep;
	logic [DATA_W-1:0] word;
	assign sel = supply_ok_i && ctl_i.rst_n && hold_r == 0 &&
		!ctl_i.ce_n;
	assign done = cnt_r >= (page_r ? PACC_CYC - 3 : ACC_CYC - 3);
	assign nap = cnt_r >= NAP_CYC;
	assign deep = cnt_r >= NAP_CYC + STBY_CYC;
	assign drv = sel && !ctl_i.oe_n && done;
	assign word = (a_r == wa_r) ? wd_r : a_r[15:0] ^ 16'h3c5a;
	// no pull on the data lines: a floated bus shows the last word inverted
	assign data_bus_o = drv ? (nap ? last_r : word) : ~last_r;
	assign ready_busy_o = supply_ok_i && ctl_i.rst_n &&
		hold_r == 0;
	always @(posedge clk_i) begin
		if (drv && !nap)
			last_r <= word;
		a_r <= address_bus_i;
		wr_r <= sel && !ctl_i.we_n;
		// a supply dip reloads the hold like a cold reset
		if (!ctl_i.rst_n || !supply_ok_i)
			hold_r <= RPH_CYC - 2;
		else if (hold_r != 0)
			hold_r <= hold_r - 1;
		if (!sel || a_r != address_bus_i) begin
			cnt_r <= '0;
			page_r <= sel && done && !ctl_i.oe_n &&
				a_r[ADDR_W-1:PAGE_W] == address_bus_i[ADDR_W-1:PAGE_W];
		end else if (cnt_r != 8'hff)
			cnt_r <= cnt_r + 1;
		if (sel && !ctl_i.we_n && !wr_r)
			wa_r <= address_bus_i;
		if (wr_r && supply_ok_i && ctl_i.rst_n && !(sel && !ctl_i.we_n))
			wd_r <= data_bus_i;
	end
endmodule // afhi_flash_model

/* File: test/afhi_host_test.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
	$display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module afhi_host_test;
	import afhi_pkg::*;
	logic              clk_i = 1'b0;
	logic              rst_i = 1'b1;
	logic              req_valid_i = 1'b0;
	afhi_req_type      req_i = '0;
	logic              req_ready_o, rsp_valid_o, data_bus_oe_o, rb;
	logic              busy_o, flash_ready_o;
	logic              vcc_ok = 1'b1;
	logic [DATA_W-1:0] rsp_data_o, h_dq, f_dq, bus;
	logic [ADDR_W-1:0] address_bus_o;
	afhi_ctl_type      ctl_o;
	int                n_errors = 0, total_checks = 0, low_n = 0, last_low = 0;
	int                n;
	assign bus = data_bus_oe_o ? h_dq : f_dq;
	afhi_host i_afhi_host (.clk_i(clk_i), .rst_i(rst_i),
		.req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
		.rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .ctl_o(ctl_o),
		.address_bus_o(address_bus_o), .data_bus_o(h_dq),
		.data_bus_oe_o(data_bus_oe_o), .data_bus_i(bus), .ready_busy_i(rb),
		.busy_o(busy_o), .flash_ready_o(flash_ready_o));
	afhi_flash_model i_afhi_flash_model (.clk_i(clk_i), .ctl_i(ctl_o),
		.address_bus_i(address_bus_o), .data_bus_i(bus), .data_bus_o(f_dq),
		.ready_busy_o(rb), .supply_ok_i(vcc_ok));
	initial forever #2.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (!rst_i && !ctl_o.oe_n) `CHK(ctl_o.we_n, 1'b1)
		if (!rst_i && !ctl_o.rst_n) `CHK(ctl_o.ce_n, 1'b1)
		low_n <= (ctl_o.rst_n || rst_i) ? 0 : low_n + 1;
		if (ctl_o.rst_n && low_n != 0) last_low <= low_n;
	end
	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wait_ready();
		int i;
		for (i = 0; !(req_ready_o === 1'b1); i++) begin
			if (i > 200) begin n_errors++; end_sim(); end
			@(posedge clk_i);
			#1;
		end
	endtask
	// n counts edges from take to answer; write and reset end on ready
	task automatic op(input afhi_cmd_type c, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		wait_ready();
		@(posedge clk_i);
		req_i <= '{cmd: c, addr: a, wdata: d};
		req_valid_i <= 1'b1;
		@(posedge clk_i);
		req_valid_i <= 1'b0;
		#1;
		for (n = 0; c == AFHI_CMD_READ ? rsp_valid_o !== 1'b1 :
			req_ready_o !== 1'b1; n++) begin
			if (n > 200) begin n_errors++; end_sim(); end
			@(posedge clk_i);
			#1;
		end
	endtask
	task automatic t_read();
		op(AFHI_CMD_READ, 26'h0123450, '0);
		`CHK(n, ACC_CYC + 2)
		`CHK(rsp_data_o, 16'h3450 ^ 16'h3c5a)
		op(AFHI_CMD_READ, 26'h0123453, '0);
		`CHK(n, PACC_CYC + 2)
		`CHK(rsp_data_o, 16'h3453 ^ 16'h3c5a)
		op(AFHI_CMD_READ, 26'h0123453, '0);
		`CHK(n, OE_CYC + 2)
		`CHK(rsp_data_o, 16'h3453 ^ 16'h3c5a)
		repeat (60) @(posedge clk_i);
		#1;
		`CHK(i_afhi_flash_model.nap, 1'b1)
		`CHK(i_afhi_flash_model.deep, 1'b1)
		op(AFHI_CMD_READ, 26'h0123453, '0);
		`CHK(n, OE_CYC + 2)
		`CHK(rsp_data_o, 16'h3453 ^ 16'h3c5a)
		op(AFHI_CMD_READ, 26'h0124453, '0);
		`CHK(n, ACC_CYC + 2)
		`CHK(rsp_data_o, 16'h4453 ^ 16'h3c5a)
		$display("read test done");
	endtask
	task automatic t_write();
		op(AFHI_CMD_WRITE, 26'h0124453, 16'hbeef);
		`CHK(n, AS_CYC + WP_CYC + WH_CYC + 3)
		`CHK(ctl_o.ce_n, 1'b1)
		op(AFHI_CMD_READ, 26'h0124453, '0);
		`CHK(n, ACC_CYC + 2)
		`CHK(rsp_data_o, 16'hbeef)
		$display("write test done");
	endtask
	task automatic t_reset();
		op(AFHI_CMD_RESET, '0, '0);
		`CHK(last_low, RP_CYC + 1)
		`CHK(flash_ready_o, 1'b1)
		op(AFHI_CMD_READ, 26'h0000021, '0);
		`CHK(rsp_data_o, 16'h0021 ^ 16'h3c5a)
		$display("reset test done");
	endtask
	task automatic t_supply();
		vcc_ok <= 1'b0;
		op(AFHI_CMD_WRITE, 26'h0000077, 16'h1234);
		`CHK(flash_ready_o, 1'b0)
		vcc_ok <= 1'b1;
		op(AFHI_CMD_RESET, '0, '0);
		`CHK(flash_ready_o, 1'b1)
		op(AFHI_CMD_READ, 26'h0000077, '0);
		`CHK(rsp_data_o, 16'h0077 ^ 16'h3c5a)
		$display("supply test done");
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		wait_ready();
		`CHK(busy_o, 1'b0)
		t_read();
		t_write();
		t_reset();
		t_supply();
		end_sim();
	end
endmodule // afhi_host_test
